/* File: core/rpms_device.sv */
// device end: reset pin sequencer, cause record, mode select and debug pin driver
`timescale 1ns/10ps
`default_nettype none
module rpms_device
	import rpms_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// internal reset sources
	input wire logic lvd_rst_i,
	input wire logic wdog_rst_i,
	// clock selections
	input wire logic stop_self_clk_sel_i,
	input wire logic dbg_self_clk_sel_i,
	input wire logic bus_clk_tick_i,
	// port bit use of the background pin
	input wire logic port_g_bit_zero_en_i,
	input wire logic port_g_bit_zero_i,
	// debug bit to send
	input wire logic dbg_tx_start_i,
	input wire logic dbg_tx_bit_i,
	// pins
	rpms_if.device pins,
	// status
	output logic [CAUSE_W-1:0] reset_cause_register_o,
	output logic bkgd_mode_o,
	output logic in_reset_o,
	output logic pin_check_fail_o,
	output logic stop_clk_self_o,
	output logic dbg_busy_o,
	output logic dbg_rx_bit_o
);
	rpms_state_e state_reg;
	logic [$clog2(SELF_DIV)-1:0] div_reg;
	logic self_tick;
	logic [5:0] cnt_reg;
	logic [1:0] rst_sync_reg;
	logic [1:0] bkgd_sync_reg;
	logic internal_reg;
	logic [CAUSE_W-1:0] pend_reg;
	logic [3:0] bit_cnt_reg;
	logic [1:0] su_cnt_reg;
	logic tx_bit_reg;
	logic dbg_tick;

	// two-flop synchronisers for both pins
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_reg <= 2'h3;
			bkgd_sync_reg <= 2'h3;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], pins.rst_level};
			bkgd_sync_reg <= {bkgd_sync_reg[0], pins.bkgd_level};
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_reg <= '0;
		end else if (div_reg == ($clog2(SELF_DIV))'(SELF_DIV - 1)) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end
	assign self_tick = (div_reg == ($clog2(SELF_DIV))'(SELF_DIV - 1));

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= RPMS_ST_DRIVE;
			cnt_reg <= '0;
			internal_reg <= 1'b0;
			pin_check_fail_o <= 1'b0;
		end else begin
			unique case (state_reg)
				RPMS_ST_IDLE, RPMS_ST_RUN: begin
					if (lvd_rst_i || wdog_rst_i || !rst_sync_reg[1]) begin
						state_reg <= RPMS_ST_DRIVE;
						cnt_reg <= '0;
						internal_reg <= lvd_rst_i || wdog_rst_i;
					end
				end
				RPMS_ST_DRIVE: begin
					if (self_tick) begin
						if (cnt_reg == 6'(DRIVE_SELF_CYC - 1)) begin
							state_reg <= RPMS_ST_WAIT;
							cnt_reg <= '0;
						end else begin
							cnt_reg <= cnt_reg + 1'b1;
						end
					end
				end
				RPMS_ST_WAIT: begin
					if (self_tick) begin
						if (cnt_reg == 6'(SAMPLE_SELF_CYC - 1)) begin
							// the resample; an internal reset expects the pin back high
							pin_check_fail_o <= internal_reg && !rst_sync_reg[1];
							state_reg <= RPMS_ST_CHECK;
						end else begin
							cnt_reg <= cnt_reg + 1'b1;
						end
					end
				end
				RPMS_ST_CHECK: begin
					// pin still held low externally keeps us in reset
					if (rst_sync_reg[1]) begin
						state_reg <= RPMS_ST_RUN;
					end
				end
				default: state_reg <= RPMS_ST_DRIVE;
			endcase
		end
	end
	assign in_reset_o = (state_reg != RPMS_ST_RUN);

	// cause decode, latched at reset start, published on release
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pend_reg <= CAUSE_RST;
			reset_cause_register_o <= CAUSE_RST;
		end else if (state_reg == RPMS_ST_RUN &&
				(lvd_rst_i || wdog_rst_i || !rst_sync_reg[1])) begin
			pend_reg <= '0;
			pend_reg[CAUSE_LVD] <= lvd_rst_i;
			pend_reg[CAUSE_WDOG] <= wdog_rst_i && !lvd_rst_i;
			pend_reg[CAUSE_PIN] <= !lvd_rst_i && !wdog_rst_i;
		end else if (state_reg == RPMS_ST_CHECK && rst_sync_reg[1]) begin
			reset_cause_register_o <= pend_reg;
		end
	end

	// mode sampled at reset release, held until next reset
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bkgd_mode_o <= 1'b0;
		end else if (state_reg == RPMS_ST_CHECK && rst_sync_reg[1]) begin
			bkgd_mode_o <= !bkgd_sync_reg[1];
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stop_clk_self_o <= 1'b1;
		end else begin
			stop_clk_self_o <= stop_self_clk_sel_i;
		end
	end

	// debug clock from self clock or bus clock
	assign dbg_tick = dbg_self_clk_sel_i ? self_tick : bus_clk_tick_i;

	// one debug bit, 16 debug clocks, speed-up pulse on release
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bit_cnt_reg <= '0;
			dbg_busy_o <= 1'b0;
			tx_bit_reg <= 1'b1;
			su_cnt_reg <= '0;
			dbg_rx_bit_o <= 1'b1;
		end else if (state_reg != RPMS_ST_RUN) begin
			// a reset abandons the bit so the pin stays free for mode select
			dbg_busy_o <= 1'b0;
			su_cnt_reg <= '0;
		end else begin
			if (su_cnt_reg != '0) begin
				su_cnt_reg <= su_cnt_reg - 1'b1;
			end
			if (!dbg_busy_o) begin
				if (dbg_tx_start_i && state_reg == RPMS_ST_RUN && !port_g_bit_zero_en_i) begin
					dbg_busy_o <= 1'b1;
					bit_cnt_reg <= '0;
					tx_bit_reg <= dbg_tx_bit_i;
				end
			end else if (dbg_tick) begin
				if (bit_cnt_reg == 4'(BIT_DBG_CYC / 2)) begin
					dbg_rx_bit_o <= bkgd_sync_reg[1];
				end
				if (bit_cnt_reg == 4'(BIT_DBG_CYC - 1)) begin
					dbg_busy_o <= 1'b0;
					su_cnt_reg <= 2'(SPEEDUP_CYC);
				end
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
			end
		end
	end

	// reset pin driven low only during drive phase
	assign pins.dev_rst_o = 1'b0;
	assign pins.dev_rst_oe = (state_reg == RPMS_ST_DRIVE);
	// port bit use drives only; speed-up drives high
	always_comb begin
		pins.dev_bkgd_o = 1'b1;
		pins.dev_bkgd_oe = 1'b0;
		if (state_reg != RPMS_ST_RUN) begin
			// nothing drives the pin while it selects the mode
			pins.dev_bkgd_oe = 1'b0;
		end else if (port_g_bit_zero_en_i) begin
			pins.dev_bkgd_o = port_g_bit_zero_i;
			pins.dev_bkgd_oe = 1'b1;
		end else if (dbg_busy_o && bit_cnt_reg < 4'(BIT_DBG_CYC / 4)) begin
			pins.dev_bkgd_o = 1'b0;
			pins.dev_bkgd_oe = 1'b1;
		end else if (dbg_busy_o && !tx_bit_reg && bit_cnt_reg < 4'(BIT_DBG_CYC * 3 / 4)) begin
			pins.dev_bkgd_o = 1'b0;
			pins.dev_bkgd_oe = 1'b1;
		end else if (su_cnt_reg != '0) begin
			pins.dev_bkgd_o = 1'b1;
			pins.dev_bkgd_oe = 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: core/rpms_if.sv */
// interface: reset pin and background/mode-select pin between the two ends
`timescale 1ns/10ps
`default_nettype none
interface rpms_if;
	// device side drives
	logic dev_rst_o;
	logic dev_rst_oe;
	logic dev_bkgd_o;
	logic dev_bkgd_oe;
	// far side drives
	logic ext_rst_o;
	logic ext_rst_oe;
	logic ext_bkgd_o;
	logic ext_bkgd_oe;
	// resolved wire levels: open drain with pull-up, any driver wins low
	logic rst_level;
	logic bkgd_level;
	assign rst_level = !((dev_rst_oe && !dev_rst_o) || (ext_rst_oe && !ext_rst_o));
	assign bkgd_level = !((dev_bkgd_oe && !dev_bkgd_o) || (ext_bkgd_oe && !ext_bkgd_o));
	modport device (
		output dev_rst_o, dev_rst_oe, dev_bkgd_o, dev_bkgd_oe,
		input rst_level, bkgd_level
	);
	modport pod (
		output ext_rst_o, ext_rst_oe, ext_bkgd_o, ext_bkgd_oe,
		input rst_level, bkgd_level
	);
endinterface
`default_nettype wire

/* File: core/rpms_pkg.sv */
// package: constants and types shared by the reset/mode-select sequencer ends
package rpms_pkg;
	// self-reset clock rate and the sequencer's own clock rate
	localparam int unsigned SELF_CLK_HZ = 8000000;
	localparam int unsigned SYS_CLK_HZ = 200000000;
	// system clocks per self-reset clock cycle (8 MHz from 200 MHz)
	localparam int unsigned SELF_DIV = SYS_CLK_HZ / SELF_CLK_HZ;
	// pin drive and sample delay, in self-reset clock cycles
	localparam int unsigned DRIVE_SELF_CYC = 34;
	localparam int unsigned SAMPLE_SELF_CYC = 38;
	// background debug bit time in debug clock cycles
	localparam int unsigned BIT_DBG_CYC = 16;
	// speed-up pulse length in system clocks
	localparam int unsigned SPEEDUP_CYC = 2;
	// reset-cause bit positions
	localparam int unsigned CAUSE_W = 4;
	localparam int unsigned CAUSE_POR = 0;
	localparam int unsigned CAUSE_PIN = 1;
	localparam int unsigned CAUSE_LVD = 2;
	localparam int unsigned CAUSE_WDOG = 3;
	localparam logic [CAUSE_W-1:0] CAUSE_RST = 4'h1;
	typedef enum logic [4:0] {
		RPMS_ST_IDLE = 5'h01,
		RPMS_ST_DRIVE = 5'h02,
		RPMS_ST_WAIT = 5'h04,
		RPMS_ST_CHECK = 5'h08,
		RPMS_ST_RUN = 5'h10
	} rpms_state_e;
endpackage

/* File: core/rpms_pod.sv */
// far end: debug pod / reset switch driving the reset and background pins
`timescale 1ns/10ps
`default_nettype none
module rpms_pod
	import rpms_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// user requests
	input wire logic force_reset_i,
	input wire logic want_bkgd_i,
	input wire logic tx_start_i,
	input wire logic tx_bit_i,
	// pins
	rpms_if.pod pins,
	// status
	output logic busy_o,
	output logic rx_bit_o,
	output logic target_in_reset_o
);
	logic [1:0] rst_sync_reg;
	logic [1:0] bkgd_sync_reg;
	logic [3:0] bit_cnt_reg;
	logic [1:0] su_cnt_reg;
	logic tx_bit_reg;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_reg <= 2'h3;
			bkgd_sync_reg <= 2'h3;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], pins.rst_level};
			bkgd_sync_reg <= {bkgd_sync_reg[0], pins.bkgd_level};
		end
	end
	assign target_in_reset_o = !rst_sync_reg[1];

	// pull reset low to force a reset
	assign pins.ext_rst_o = 1'b0;
	assign pins.ext_rst_oe = force_reset_i;

	// bit timing in pod clocks, speed-up pulse on release
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			busy_o <= 1'b0;
			bit_cnt_reg <= '0;
			su_cnt_reg <= '0;
			tx_bit_reg <= 1'b1;
			rx_bit_o <= 1'b1;
		end else begin
			if (su_cnt_reg != '0) begin
				su_cnt_reg <= su_cnt_reg - 1'b1;
			end
			if (!busy_o) begin
				if (tx_start_i && rst_sync_reg[1]) begin
					busy_o <= 1'b1;
					bit_cnt_reg <= '0;
					tx_bit_reg <= tx_bit_i;
				end
			end else begin
				if (bit_cnt_reg == 4'(BIT_DBG_CYC / 2)) begin
					rx_bit_o <= bkgd_sync_reg[1];
				end
				if (bit_cnt_reg == 4'(BIT_DBG_CYC - 1)) begin
					busy_o <= 1'b0;
					su_cnt_reg <= 2'(SPEEDUP_CYC);
				end
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
			end
		end
	end

	// hold mode pin low across reset release when asked
	always_comb begin
		pins.ext_bkgd_o = 1'b1;
		pins.ext_bkgd_oe = 1'b0;
		if (want_bkgd_i && !busy_o && su_cnt_reg == '0) begin
			pins.ext_bkgd_o = 1'b0;
			pins.ext_bkgd_oe = 1'b1;
		end else if (busy_o && (bit_cnt_reg < 4'(BIT_DBG_CYC / 4) ||
				(!tx_bit_reg && bit_cnt_reg < 4'(BIT_DBG_CYC * 3 / 4)))) begin
			pins.ext_bkgd_o = 1'b0;
			pins.ext_bkgd_oe = 1'b1;
		end else if (su_cnt_reg != '0) begin
			pins.ext_bkgd_o = 1'b1;
			pins.ext_bkgd_oe = 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: verif/rpms_chk.sv */
// checker: timing of the reset and background pins
`timescale 1ns/10ps
`default_nettype none
module rpms_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// device pin drives and reset wire
	input wire logic dev_rst_o,
	input wire logic dev_rst_oe,
	input wire logic dev_bkgd_o,
	input wire logic dev_bkgd_oe,
	input wire logic rst_level,
	// port bit use of the background pin
	input wire logic port_g_bit_zero_en_i
);
	logic [11:0] hi_cnt;
	logic [11:0] lo_cnt;
	logic spd;
	// speed-up pulse: driven high while the pin is not a port bit
	assign spd = dev_bkgd_oe && dev_bkgd_o && !port_g_bit_zero_en_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// cycles the reset pin is driven, and cycles since it was released
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hi_cnt <= '0;
			lo_cnt <= 12'hFFF;
		end else if (dev_rst_oe) begin
			hi_cnt <= hi_cnt + 12'h1;
			lo_cnt <= '0;
		end else begin
			hi_cnt <= '0;
			lo_cnt <= (lo_cnt == 12'hFFF) ? lo_cnt : lo_cnt + 12'h1;
		end
	end
	AST_RST_LOW_ONLY: assert property (dev_rst_oe |-> !dev_rst_o && !rst_level)
		else $error("reset pin not pulled low");
	AST_RST_LEN: assert property ($fell(dev_rst_oe) |-> hi_cnt >= 12'h33A && hi_cnt <= 12'h353)
		else $error("reset drive length off");
	AST_RST_HOLD: assert property ($rose(dev_rst_oe) |-> dev_rst_oe [*8])
		else $error("reset drive cut short");
	AST_RST_GAP: assert property ($rose(dev_rst_oe) |-> lo_cnt >= 12'h39D)
		else $error("reset redriven before resample");
	AST_EXT_TAKE: assert property ($fell(rst_level) && !dev_rst_oe && lo_cnt > 12'h3E8
		|-> ##[1:6] dev_rst_oe)
		else $error("external reset not taken");
	AST_BKGD_QUIET: assert property (dev_rst_oe |-> !dev_bkgd_oe)
		else $error("background pin driven in reset");
	AST_SPD_LEN: assert property ($rose(spd) |-> spd [*2] ##1 !spd)
		else $error("speed-up pulse length off");
	AST_SPD_AFTER: assert property ($rose(spd) |-> !$past(dev_bkgd_oe))
		else $error("speed-up without release");
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// testbench: device and pod joined through the pin interface
`timescale 1ns/10ps
`default_nettype none
module testbench
	import rpms_pkg::*;
;
	logic clk_i = 1'b0, nrst_i = 1'b0, lvd_rst_i = 1'b0, wdog_rst_i = 1'b0;
	logic stop_self_clk_sel_i = 1'b1, dbg_self_clk_sel_i = 1'b0, bus_clk_tick_i = 1'b1;
	logic port_g_bit_zero_en_i = 1'b0, port_g_bit_zero_i = 1'b0, dbg_tx_start_i = 1'b0;
	logic dbg_tx_bit_i = 1'b0, force_reset_i = 1'b0, want_bkgd_i = 1'b0;
	logic tx_start_i = 1'b0, tx_bit_i = 1'b0, b;
	logic [CAUSE_W-1:0] reset_cause_register_o;
	logic bkgd_mode_o, in_reset_o, pin_check_fail_o, stop_clk_self_o, dbg_busy_o;
	logic dbg_rx_bit_o, busy_o, rx_bit_o, target_in_reset_o;
	int miscompares = 0, comparisons = 0;
	int bit_len;
	rpms_if pins ();
	rpms_device u_rpms_device (.clk_i, .nrst_i, .lvd_rst_i, .wdog_rst_i, .stop_self_clk_sel_i,
		.dbg_self_clk_sel_i, .bus_clk_tick_i, .port_g_bit_zero_en_i, .port_g_bit_zero_i,
		.dbg_tx_start_i, .dbg_tx_bit_i, .pins(pins), .reset_cause_register_o, .bkgd_mode_o,
		.in_reset_o, .pin_check_fail_o, .stop_clk_self_o, .dbg_busy_o, .dbg_rx_bit_o);
	rpms_pod u_rpms_pod (.clk_i, .nrst_i, .force_reset_i, .want_bkgd_i, .tx_start_i, .tx_bit_i,
		.pins(pins), .busy_o, .rx_bit_o, .target_in_reset_o);
	rpms_chk u_rpms_chk (.clk_i, .nrst_i, .dev_rst_o(pins.dev_rst_o), .dev_rst_oe(pins.dev_rst_oe),
		.dev_bkgd_o(pins.dev_bkgd_o), .dev_bkgd_oe(pins.dev_bkgd_oe), .rst_level(pins.rst_level),
		.port_g_bit_zero_en_i);
	initial begin
		forever #2.5 clk_i = !clk_i;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (miscompares == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	function automatic logic [CAUSE_W-1:0] cause_of(input int i);
		return i[0] ? 4'h1 << CAUSE_LVD : 4'h1 << CAUSE_WDOG;
	endfunction
	// busy span of one bit: 16 clocks, or 16 self ticks of unknown phase
	function automatic logic bit_len_ok(input int n, input logic slow);
		if (slow) begin
			return n > (BIT_DBG_CYC - 1) * SELF_DIV && n <= BIT_DBG_CYC * SELF_DIV;
		end
		return n == BIT_DBG_CYC;
	endfunction
	// waits for a reset sequence to start and to finish
	task automatic wait_idle();
		repeat (20) if (in_reset_o !== 1'b1) @(negedge clk_i);
		repeat (4000) if (in_reset_o !== 1'b0) @(negedge clk_i);
		check(in_reset_o, 1'b0);
	endtask
	// one debug bit from the device (dev=1) or from the pod
	task automatic send(input logic dev, input logic v);
		dbg_tx_bit_i = v;
		tx_bit_i = v;
		dbg_tx_start_i = dev;
		tx_start_i = !dev;
		@(negedge clk_i);
		dbg_tx_start_i = 1'b0;
		tx_start_i = 1'b0;
		bit_len = 0;
		while ((dbg_busy_o === 1'b1 || busy_o === 1'b1) && bit_len < 500) begin
			@(negedge clk_i);
			bit_len++;
		end
		repeat (4) @(negedge clk_i);
	endtask
	initial begin
		void'($urandom(12484));
		repeat (2) @(negedge clk_i);
		nrst_i = 1'b1;
		wait_idle();
		check(reset_cause_register_o, CAUSE_RST);
		check(bkgd_mode_o, 1'b0);
		// internal causes, both at once gives low voltage
		for (int i = 1; i < 4; i++) begin
			lvd_rst_i = i[0];
			wdog_rst_i = i[1];
			stop_self_clk_sel_i = 1'($urandom);
			@(negedge clk_i);
			check(stop_clk_self_o, stop_self_clk_sel_i);
			lvd_rst_i = 1'b0;
			wdog_rst_i = 1'b0;
			wait_idle();
			check(reset_cause_register_o, cause_of(i));
			check(pin_check_fail_o, 1'b0);
		end
		// pin held low by the pod across the resample
		lvd_rst_i = 1'b1;
		@(negedge clk_i);
		lvd_rst_i = 1'b0;
		repeat (900) @(negedge clk_i);
		force_reset_i = 1'b1;
		repeat (1100) @(negedge clk_i);
		check(in_reset_o, 1'b1);
		check(target_in_reset_o, 1'b1);
		tx_start_i = 1'b1;
		@(negedge clk_i);
		tx_start_i = 1'b0;
		check(busy_o, 1'b0);
		force_reset_i = 1'b0;
		wait_idle();
		check(pin_check_fail_o, 1'b1);
		// pod reset with background mode requested
		want_bkgd_i = 1'b1;
		force_reset_i = 1'b1;
		repeat (20) @(negedge clk_i);
		force_reset_i = 1'b0;
		wait_idle();
		want_bkgd_i = 1'b0;
		check(reset_cause_register_o, 4'h1 << CAUSE_PIN);
		check(bkgd_mode_o, 1'b1);
		check(target_in_reset_o, 1'b0);
		for (int i = 0; i < 16; i++) begin
			b = (i < 4) ? i[1] : 1'($urandom);
			dbg_self_clk_sel_i = (i < 4) ? 1'b0 : (i == 5) ? 1'b1 : 1'($urandom);
			send(i[0], b);
			check(i[0] ? dbg_rx_bit_o : rx_bit_o, b);
			check(bit_len_ok(bit_len, i[0] && dbg_self_clk_sel_i), 1'b1);
		end
		dbg_self_clk_sel_i = 1'b0;
		check(bkgd_mode_o, 1'b1);
		// port bit use: driven low then high, debug start refused
		port_g_bit_zero_en_i = 1'b1;
		for (int v = 0; v < 2; v++) begin
			port_g_bit_zero_i = v[0];
			send(1'b1, 1'b1);
			check(pins.bkgd_level, v[0]);
			check(dbg_busy_o, 1'b0);
		end
		port_g_bit_zero_en_i = 1'b0;
		// watchdog reset cut by a power-on reset mid-drive
		wdog_rst_i = 1'b1;
		@(negedge clk_i);
		wdog_rst_i = 1'b0;
		repeat (100) @(negedge clk_i);
		nrst_i = 1'b0;
		@(negedge clk_i);
		nrst_i = 1'b1;
		wait_idle();
		check(reset_cause_register_o, CAUSE_RST);
		check(bkgd_mode_o, 1'b0);
		stop_test();
	end
	// hang guard, well beyond the expected run
	initial begin
		#250000;
		miscompares++;
		stop_test();
	end
endmodule
`default_nettype wire
